// ==== src/shcp_pkg.sv ====
package shcp_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CTRL_ONE = 8'h04;
  localparam logic [7:0] OFF_CTRL_THREE = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_BAUD = 8'h10;
  localparam logic [7:0] OFF_IRQ = 8'h14;
  localparam int BIT_SAMPLE_PHASE = 7;
  localparam int BIT_CLOCK_EDGE = 6;
  localparam int BIT_BUF_FULL = 0;
  localparam int BIT_COLLIDE = 7;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_POLARITY = 4;
  localparam int BIT_OVERWRITE = 4;
  localparam int BIT_IRQ = 0;
  localparam logic [7:0] RST_REG = 8'h00;
  // ****************************************
  // mode field
  // ****************************************
  localparam logic [3:0] MODE_HOST_DIV4 = 4'h0;
  localparam logic [3:0] MODE_HOST_DIV16 = 4'h1;
  localparam logic [3:0] MODE_HOST_DIV64 = 4'h2;
  localparam logic [3:0] MODE_HOST_TMR2 = 4'h3;
  localparam logic [3:0] MODE_CLIENT_SS = 4'h4;
  localparam logic [3:0] MODE_CLIENT = 4'h5;
  localparam logic [3:0] MODE_HOST_BAUD = 4'hA;
  // ****************************************
  // timing: mclk cycles per half bit, last half and bit indexes, far lead cycles
  // ****************************************
  localparam logic [9:0] HALF_DIV4 = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;
  localparam logic [4:0] HALVES_LAST = 5'h0F;
  localparam logic [4:0] HALVES_LAST_LATE = 5'h10;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [7:0] FAR_HALF = 8'h0A;
  localparam logic [7:0] FAR_LEAD = 8'h0A;
endpackage

// ==== src/shcp_link_if.sv ====
`timescale 1ns/1ps
interface shcp_link_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic far_sck_o;
  logic far_sck_oe;
  logic sck;
  logic dev_sdo_o;
  logic dev_sdo_oe;
  logic far_sdo_o;
  logic far_sdo_oe;
  logic dev_sdi;
  logic far_sdi;
  logic ss_n;
  // ****************************************
  // wire resolution, idle data lines read high
  // ****************************************
  assign sck = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : 1'b0);
  assign dev_sdi = far_sdo_oe ? far_sdo_o : 1'b1;
  assign far_sdi = dev_sdo_oe ? dev_sdo_o : 1'b1;
  modport dev (
    output dev_sck_o,
    output dev_sck_oe,
    output dev_sdo_o,
    output dev_sdo_oe,
    input sck,
    input dev_sdi,
    input ss_n
  );
  modport far (
    output far_sck_o,
    output far_sck_oe,
    output far_sdo_o,
    output far_sdo_oe,
    output ss_n,
    input sck,
    input far_sdi
  );
endinterface

// ==== src/shcp_port.sv ====
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module shcp_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tmr2_tick,
  output logic port_irq_flag,
  shcp_link_if.dev link
);
  import shcp_pkg::*;

  typedef struct packed {
    logic [7:0] sr;
    logic [7:0] buf_q;
    logic full;
    logic collide;
    logic irq;
    logic en;
    logic pol;
    logic cke;
    logic sphase;
    logic ovr;
    logic [3:0] mode;
    logic [7:0] baud;
    logic busy;
    logic [4:0] half;
    logic [9:0] tick;
    logic [3:0] bits;
    logic [2:0] sck_sy;
    logic [2:0] ss_sy;
    logic [2:0] sdi_sy;
    logic sck_lvl;
    logic ss_lvl;
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } shcp_state_s;

  shcp_state_s q;
  shcp_state_s n;
  logic host;
  logic client;
  logic gated;
  logic [9:0] half_len;
  logic step;
  logic smp_now;
  logic chg_now;
  logic lead;
  logic done;
  logic acc;

  always_comb begin
    host = (q.mode == MODE_HOST_DIV4) || (q.mode == MODE_HOST_DIV16) ||
           (q.mode == MODE_HOST_DIV64) || (q.mode == MODE_HOST_TMR2) ||
           (q.mode == MODE_HOST_BAUD);
    client = (q.mode == MODE_CLIENT_SS) || (q.mode == MODE_CLIENT);
    gated = (q.mode == MODE_CLIENT_SS) && q.ss_lvl;
    unique case (q.mode)
      MODE_HOST_DIV16: half_len = HALF_DIV16;
      MODE_HOST_DIV64: half_len = HALF_DIV64;
      MODE_HOST_BAUD: half_len = {1'b0, q.baud, 1'b0} + HALF_DIV4;
      default: half_len = HALF_DIV4;
    endcase
    n = q;
    done = 1'b0;
    step = 1'b0;
    smp_now = 1'b0;
    chg_now = 1'b0;
    lead = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // ****************************************
    // pin synchronisers
    // ****************************************
    n.sck_sy = {q.sck_sy[1:0], link.sck};
    n.ss_sy = {q.ss_sy[1:0], link.ss_n};
    n.sdi_sy = {q.sdi_sy[1:0], link.dev_sdi};
    if (q.ss_sy[1] == q.ss_sy[2]) begin
      n.ss_lvl = q.ss_sy[2];
    end
    // ****************************************
    // apb slave, one wait state
    // ****************************************
    acc = psel && penable && !q.pready;
    if (acc) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      unique case (paddr)
        OFF_STATUS: begin
          n.prdata[BIT_SAMPLE_PHASE] = q.sphase;
          n.prdata[BIT_CLOCK_EDGE] = q.cke;
          n.prdata[BIT_BUF_FULL] = q.full;
          if (pwrite) begin
            n.sphase = pwdata[BIT_SAMPLE_PHASE];
            n.cke = pwdata[BIT_CLOCK_EDGE];
          end
        end
        OFF_CTRL_ONE: begin
          n.prdata[7:0] = {q.collide, 1'b0, q.en, q.pol, q.mode};
          if (pwrite) begin
            n.collide = q.collide && pwdata[BIT_COLLIDE];
            n.en = pwdata[BIT_ENABLE];
            n.pol = pwdata[BIT_POLARITY];
            n.mode = pwdata[3:0];
          end
        end
        OFF_CTRL_THREE: begin
          n.prdata[BIT_OVERWRITE] = q.ovr;
          if (pwrite) begin
            n.ovr = pwdata[BIT_OVERWRITE];
          end
        end
        OFF_DATA: begin
          n.prdata[7:0] = q.buf_q;
          if (!pwrite) begin
            n.full = 1'b0;
          end else if (q.busy || (client && q.bits != 4'h0)) begin
            n.collide = 1'b1;
          end else if (!q.collide && (q.ovr || !q.full)) begin
            n.buf_q = pwdata[7:0];
            n.sr = pwdata[7:0];
            n.sdo_o = pwdata[7];
            n.bits = 4'h0;
            n.half = 5'h00;
            n.tick = 10'h000;
            n.busy = host && q.en;
          end
        end
        OFF_BAUD: begin
          n.prdata[7:0] = q.baud;
          if (pwrite) begin
            n.baud = pwdata[7:0];
          end
        end
        OFF_IRQ: begin
          n.prdata[BIT_IRQ] = q.irq;
          if (pwrite && pwdata[BIT_IRQ]) begin
            n.irq = 1'b0;
          end
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    // ****************************************
    // host engine
    // ****************************************
    if (host && q.busy) begin
      if (q.mode == MODE_HOST_TMR2) begin
        step = tmr2_tick;
      end else begin
        n.tick = q.tick + 10'h001;
        step = (q.tick == half_len - 10'h001);
      end
      if (step) begin
        n.tick = 10'h000;
        n.half = q.half + 5'h01;
        if (q.half <= HALVES_LAST) begin
          n.sck_o = !q.sck_o;
        end
        smp_now = (q.half[0] == (q.cke ~^ q.sphase)) && (q.half != 5'h00 || q.cke);
        chg_now = q.cke ? (q.half[0] && q.half < HALVES_LAST) :
                  (!q.half[0] && q.half <= HALVES_LAST);
        if (smp_now) begin
          n.sr = {q.sr[6:0], q.sdi_sy[2]};
        end
        if (chg_now) begin
          n.sdo_o = n.sr[7];
        end
        if (q.half == ((!q.cke && q.sphase) ? HALVES_LAST_LATE : HALVES_LAST)) begin
          n.busy = 1'b0;
          done = 1'b1;
        end
      end
    end
    // ****************************************
    // client engine
    // ****************************************
    if (q.sck_sy[1] == q.sck_sy[2] && q.sck_sy[2] != q.sck_lvl) begin
      n.sck_lvl = q.sck_sy[2];
      if (client && q.en && !gated) begin
        lead = (q.sck_sy[2] != q.pol);
        if (lead == q.cke) begin
          n.sr = {q.sr[6:0], q.sdi_sy[2]};
          n.bits = q.bits + 4'h1;
          if (q.bits == BITS_LAST) begin
            n.bits = 4'h0;
            done = 1'b1;
          end
        end else begin
          n.sdo_o = q.sr[7];
        end
      end
    end
    if (client && gated) begin
      n.bits = 4'h0;
    end
    // ****************************************
    // completion, set wins over clear
    // ****************************************
    if (done) begin
      n.buf_q = n.sr;
      n.full = 1'b1;
      n.irq = 1'b1;
    end
    // ****************************************
    // pin drive and disable
    // ****************************************
    if (!n.en) begin
      n.busy = 1'b0;
      n.bits = 4'h0;
      n.half = 5'h00;
    end
    if (!n.busy) begin
      n.sck_o = n.pol;
    end
    n.sck_oe = n.en && host;
    n.sdo_oe = n.en && (host || (client && !((n.mode == MODE_CLIENT_SS) && n.ss_lvl)));
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '{ss_sy: 3'h7, ss_lvl: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign port_irq_flag = q.irq;
  assign link.dev_sck_o = q.sck_o;
  assign link.dev_sck_oe = q.sck_oe;
  assign link.dev_sdo_o = q.sdo_o;
  assign link.dev_sdo_oe = q.sdo_oe;
endmodule

// ==== src/shcp_far_host.sv ====
`timescale 1ns/1ps
module shcp_far_host (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] tx_data,
  input wire logic pol,
  input wire logic cke,
  output logic busy,
  output logic done,
  output logic [7:0] rx_data,
  shcp_link_if.far link
);
  import shcp_pkg::*;

  typedef enum logic [1:0] {
    SHCP_IDLE = 2'b00,
    SHCP_LEAD = 2'b01,
    SHCP_SHIFT = 2'b10,
    SHCP_TAIL = 2'b11
  } shcp_far_e;

  typedef struct packed {
    shcp_far_e st;
    logic [7:0] sr;
    logic [7:0] cnt;
    logic [4:0] half;
    logic [2:0] sdi_sy;
    logic sck_o;
    logic sdo_o;
    logic ss_n;
    logic busy;
    logic done;
    logic [7:0] rx;
  } shcp_far_s;

  shcp_far_s q;
  shcp_far_s n;

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.sdi_sy = {q.sdi_sy[1:0], link.far_sdi};
    n.cnt = q.cnt + 8'h01;
    unique case (q.st)
      SHCP_IDLE: begin
        n.sck_o = pol;
        n.ss_n = 1'b1;
        n.cnt = 8'h00;
        if (start) begin
          n.st = SHCP_LEAD;
          n.ss_n = 1'b0;
          n.sr = tx_data;
          n.sdo_o = tx_data[7];
          n.busy = 1'b1;
        end
      end
      SHCP_LEAD: begin
        if (q.cnt == FAR_LEAD - 8'h01) begin
          n.st = SHCP_SHIFT;
          n.cnt = 8'h00;
          n.half = 5'h00;
        end
      end
      SHCP_SHIFT: begin
        if (q.cnt == FAR_HALF - 8'h01) begin
          n.cnt = 8'h00;
          n.half = q.half + 5'h01;
          n.sck_o = !q.sck_o;
          if (q.half[0] == !cke) begin
            n.sr = {q.sr[6:0], q.sdi_sy[2]};
          end
          if (cke ? (q.half[0] && q.half < HALVES_LAST) : !q.half[0]) begin
            n.sdo_o = n.sr[7];
          end
          if (q.half == HALVES_LAST) begin
            n.st = SHCP_TAIL;
          end
        end
      end
      SHCP_TAIL: begin
        if (q.cnt == FAR_HALF - 8'h01) begin
          n.st = SHCP_IDLE;
          n.ss_n = 1'b1;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.rx = q.sr;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '{st: SHCP_IDLE, ss_n: 1'b1, default: '0};
    end else begin
      q <= n;
    end
  end

  assign busy = q.busy;
  assign done = q.done;
  assign rx_data = q.rx;
  assign link.far_sck_o = q.sck_o;
  assign link.far_sck_oe = 1'b1;
  assign link.far_sdo_o = q.sdo_o;
  assign link.far_sdo_oe = 1'b1;
  assign link.ss_n = q.ss_n;
endmodule

// ==== testbench/shcp_port_assertions.sv ====
`timescale 1ns/1ps
module shcp_port_assertions (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic dev_sck_oe,
  input wire logic dev_sdo_o,
  input wire logic dev_sdo_oe,
  input wire logic far_sdo_o
);
  // ********
  // helper counters
  // ********
  logic sck_q;
  logic ss_q;
  logic [4:0] toggles;
  logic [3:0] gap;
  logic ev;
  assign ev = (sck != sck_q) || (ss_n != ss_q);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sck_q <= 1'b0;
      ss_q <= 1'b1;
      toggles <= 5'h00;
      gap <= 4'hF;
    end else begin
      sck_q <= sck;
      ss_q <= ss_n;
      if (ss_q && !ss_n) begin
        toggles <= 5'h00;
      end else if (!ss_n && sck != sck_q) begin
        toggles <= toggles + 5'h01;
      end
      if (ev) begin
        gap <= 4'h0;
      end else if (gap != 4'hF) begin
        gap <= gap + 4'h1;
      end
    end
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence sel_start;
    $fell(ss_n);
  endsequence
  sequence sel_end;
    $rose(ss_n);
  endsequence
  AST_SEL_FLOAT: assert property (sel_end |-> ##[1:5] !dev_sdo_oe)
    else $error("data output still driven after deselect");
  AST_UNSEL_QUIET: assert property (ss_n [*6] ##0 !dev_sck_oe |-> !dev_sdo_oe)
    else $error("unselected port drives data");
  AST_SEL_DRIVE: assert property (sel_start |-> ##[1:6] dev_sdo_oe)
    else $error("no data driven before first clock edge");
  AST_LEAD_STILL: assert property (sel_start |-> $stable(sck) [*8])
    else $error("clock moved during select lead");
  AST_TAIL_STILL: assert property (sel_end |-> $stable(sck) [*3])
    else $error("clock moved at deselect");
  AST_FRAME_LEN: assert property (sel_end |-> toggles == 5'h10)
    else $error("frame clock edge count wrong");
  AST_CLIENT_NO_SCK: assert property (!ss_n |-> !dev_sck_oe)
    else $error("client drives clock");
  AST_DEV_SDO_EDGE: assert property (!ss_n && $changed(dev_sdo_o) |-> ev || gap <= 4'h6)
    else $error("port data changed away from clock edge");
  AST_FAR_SDO_EDGE: assert property ($changed(far_sdo_o) |-> ev || gap <= 4'h2)
    else $error("far data changed away from clock edge");
endmodule

// ==== testbench/test_spi_host_client_port.sv ====
`timescale 1ns/1ps
module test_spi_host_client_port;
  import shcp_pkg::*;
  logic mclk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic port_irq_flag;
  logic start;
  logic [7:0] tx_data;
  logic pol;
  logic tmr2_tick;
  logic cke;
  logic done;
  logic [7:0] rx_data;
  int error_cnt;
  int total_checks;
  logic [33:0] rd_q[$];
  logic [7:0] rx_q[$];
  logic [33:0] e;
  logic [7:0] a;
  logic [7:0] b;
  shcp_link_if link ();
  shcp_port i_shcp_port (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tmr2_tick(tmr2_tick), .port_irq_flag(port_irq_flag),
    .link(link.dev));
  shcp_far_host i_shcp_far_host (.mclk(mclk), .reset(reset), .start(start),
    .tx_data(tx_data), .pol(pol), .cke(cke), .busy(), .done(done), .rx_data(rx_data),
    .link(link.far));
  shcp_port_assertions i_shcp_port_assertions (.mclk(mclk), .reset(reset), .sck(link.sck),
    .ss_n(link.ss_n), .dev_sck_oe(link.dev_sck_oe), .dev_sdo_o(link.dev_sdo_o),
    .dev_sdo_oe(link.dev_sdo_oe), .far_sdo_o(link.far_sdo_o));
  always #10 mclk = ~mclk;
  always @(posedge mclk) tmr2_tick <= ($urandom() % 4) == 0;
  // ********
  // tasks
  // ********
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic timeout();
    error_cnt++;
    $display("BAD %0t wait timed out", $time);
    final_report();
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) timeout();
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [33:0] x);
    rd_q.push_back(x);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic go(input logic [7:0] d);
    @(posedge mclk);
    start <= 1'b1;
    tx_data <= d;
    @(posedge mclk);
    start <= 1'b0;
  endtask
  task automatic fin();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (done !== 1'b1 && n < 400);
    if (n >= 400) timeout();
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (port_irq_flag !== 1'b1 && n < 400);
    if (n >= 400) timeout();
  endtask
  task automatic xfer(input logic [7:0] d);
    go(d);
    fin();
  endtask
  task automatic cfg(input logic p, input logic k);
    wr(OFF_CTRL_ONE, 32'h0);
    wr(OFF_STATUS, {24'h0, 1'b0, k, 6'h0});
    pol <= p;
    cke <= k;
    wr(OFF_CTRL_ONE, {24'h0, 3'b001, p, MODE_CLIENT_SS});
  endtask
  // ********
  // monitors
  // ********
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = rd_q.pop_front();
      check({pslverr, e[33] ? e[31:0] : prdata}, e[32:0]);
    end
    if (done === 1'b1) begin
      check({25'h0, rx_data}, {25'h0, rx_q.pop_front()});
    end
  end
  // ********
  // sequence
  // ********
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start = 1'b0;
    tx_data = 8'h00;
    pol = 1'b0;
    cke = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(32'hC557));
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 34'h0);
    rd(8'h40, {2'b11, 32'h0});
    for (int c = 0; c < 4; c++) begin
      cfg(c[0], c[1]);
      check({32'h0, link.sck}, {32'h0, c[0]});
      a = 8'($urandom());
      b = 8'($urandom());
      wr(OFF_DATA, {24'h0, a});
      rx_q.push_back(a);
      xfer(b);
      check({32'h0, port_irq_flag}, 33'h1);
      rd(OFF_STATUS, {26'h0, 1'b0, c[1], 6'h01});
      rd(OFF_IRQ, 34'h1);
      wr(OFF_IRQ, 32'h1);
      rd(OFF_DATA, {26'h0, b});
      rd(OFF_STATUS, {26'h0, 1'b0, c[1], 6'h00});
    end
    check({32'h0, port_irq_flag}, 33'h0);
    wr(OFF_DATA, {24'h0, a});
    rx_q.push_back(a);
    go(b);
    repeat (40) @(posedge mclk);
    wr(OFF_DATA, {24'h0, ~a});
    fin();
    rd(OFF_CTRL_ONE, 34'hB4);
    rd(OFF_DATA, {26'h0, b});
    wr(OFF_DATA, 32'h5A);
    wr(OFF_CTRL_ONE, 32'h34);
    rd(OFF_CTRL_ONE, 34'h34);
    rx_q.push_back(b);
    xfer(a);
    rd(OFF_DATA, {26'h0, a});
    wr(OFF_DATA, 32'hC3);
    rx_q.push_back(8'hC3);
    xfer(b);
    wr(OFF_DATA, 32'h3C);
    rx_q.push_back(b);
    xfer(a);
    wr(OFF_CTRL_THREE, 32'h10);
    rd(OFF_CTRL_THREE, 34'h10);
    wr(OFF_DATA, 32'h96);
    rx_q.push_back(8'h96);
    xfer(b);
    rd(OFF_DATA, {26'h0, b});
    wr(OFF_CTRL_ONE, 32'h0);
    wr(OFF_IRQ, 32'h1);
    check({32'h0, port_irq_flag}, 33'h0);
    wr(OFF_CTRL_ONE, {24'h0, 4'h2, MODE_HOST_TMR2});
    wr(OFF_DATA, {24'h0, a});
    wait_irq();
    check({32'h0, link.sck}, 33'h0);
    rd(OFF_DATA, {26'h0, {8{b[0]}}});
    rd(OFF_STATUS, {26'h0, 8'h40});
    repeat (5) @(posedge mclk);
    final_report();
  end
endmodule
